// ===== hw/rcs_pkg.sv
// Constants and types for the radiometer commutator sequencer
package rcs_pkg;
    // Address register: two 2-stage Johnson counters
    localparam int JC_W = 2;
    localparam int EN_W = 4;
    localparam logic [JC_W-1:0] JC_S0 = 2'h0;
    localparam logic [JC_W-1:0] JC_S1 = 2'h1;
    localparam logic [JC_W-1:0] JC_S2 = 2'h3;
    localparam logic [JC_W-1:0] JC_S3 = 2'h2;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
    // Power-up state: last address, video half (frame state 32)
    localparam logic [JC_W-1:0] MEM_RST = JC_S3;
    localparam logic [JC_W-1:0] GRP_RST = JC_S3;
    // Power-up hold time
    localparam int POR_HOLD_US = 100000;
    localparam int CLK_MHZ = 200;
    localparam int POR_HOLD_CYC = POR_HOLD_US * CLK_MHZ;
    localparam int POR_CNT_W = 25;
    // Marker divider taps
    localparam int DIV_W = 4;
    localparam int DIV_TAP_300 = 2;
    localparam int DIV_TAP_150 = 3;
    // Input synchroniser lanes
    localparam int SYN_W = 4;
    localparam int SYN_ON = 0;
    localparam int SYN_OFF = 1;
    localparam int SYN_MARK = 2;
    localparam int SYN_SPG = 3;
    // Fixed analog input wiring of each commutator
    localparam int CH_VIDEO = 1;
    localparam int CH_TIME_CODE = 3;
    localparam int CH_GROUND_REF = 15;
    localparam int CH_FULL_SCALE = 16;
    typedef enum logic {RCS_HOLD, RCS_RUN} rcs_mode_t;
endpackage

// ===== hw/rcs_sequencer.sv
// Radiometer commutator sequencer: address register, decode, markers, sync level
`timescale 1ns/1ps
// Functional notes
// R1: Two isolated 16-input commutators, shared addressing
// R2: Video alternates with each telemetry input
// R3: Video held through housing scan each frame
// R4: Three-level switch tree decoded from address
// R5: Telemetry needs path, group, member; exclusive
// R6: Group on eight states, member two
// R7: Four flip-flops, two 2-stage Johnson counters
// R8: Address times latch level gives 32 states
// R9: Latch set by on, cleared by off
// R10: Radiometer supplies on/off timing signals
// R11: Members from one counter, groups other
// R12: Video frame select decodes timing state 2
// R13: Old channel off before new one on
// R14: Power-up forces state 32 about 100 ms; code holds only the address, the latch still follows on/off
// R15: Reset asynchronous; advancing resumes after release
// R16: Input 16 full scale, input 15 ground
// R17: Divider makes 300 Hz, 150 Hz from 2.4 kHz
// R18: 300 Hz to IR, 150 Hz to visible
// R19: Time code on input 3 every frame
// R20: Sync output ground when input high
// R21: One address step per latch rising edge
module rcs_sequencer #(
    parameter int POR_HOLD_CYCLES = rcs_pkg::POR_HOLD_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Radiometer timing pins
    input wire logic telemetry_window_begin,
    input wire logic video_window_begin,
    // Marker reference and sync gate pins
    input wire logic marker_ref_2k4,
    input wire logic sync_pulse_gate_out,
    // Switch tree drive, common to both commutators
    output logic [rcs_pkg::EN_W-1:0] group_en_q,
    output logic [rcs_pkg::EN_W-1:0] member_en_q,
    output logic tlm_path_en_q,
    output logic video_path_en_q,
    output logic frame_cal_sel_q,
    // Markers and sync level
    output logic marker_ir_q,
    output logic marker_vis_q,
    output logic sync_neg_drive_q
);
    import rcs_pkg::*;

    localparam int VEC_W = 2 * EN_W + 3;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic [EN_W-1:0] jc_decode(input logic [JC_W-1:0] s);
        // Two-input gates per enable
        jc_decode[0] = !s[1] && !s[0];
        jc_decode[1] = !s[1] && s[0];
        jc_decode[2] = s[1] && s[0];
        jc_decode[3] = s[1] && !s[0];
    endfunction

    function automatic logic [1:0] jc_index(input logic [JC_W-1:0] s);
        case (s)
            JC_S0: jc_index = 2'h0;
            JC_S1: jc_index = 2'h1;
            JC_S2: jc_index = 2'h2;
            default: jc_index = 2'h3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [SYN_W-1:0] sync1_q;
    logic [SYN_W-1:0] sync1_d;
    logic [SYN_W-1:0] sync2_q;
    logic [SYN_W-1:0] sync2_d;
    logic [SYN_W-1:0] pins;
    logic on_s, off_s, mark_s, spg_s;

    assign pins = {sync_pulse_gate_out, marker_ref_2k4, video_window_begin, telemetry_window_begin};

    // Pins are asynchronous: only the second stage is read
    always_comb begin
        sync1_d = pins;
        sync2_d = sync1_q;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign on_s = sync2_q[SYN_ON];
    assign off_s = sync2_q[SYN_OFF];
    assign mark_s = sync2_q[SYN_MARK];
    assign spg_s = sync2_q[SYN_SPG];

    ////////////////////////////////////////////////////////////////////////
    // Advance latch, power-up hold, address register
    logic advance_latch_q, advance_latch_d;
    logic latch_prev_q, latch_prev_d;
    rcs_mode_t mode_q, mode_d;
    logic [POR_CNT_W-1:0] por_cnt_q, por_cnt_d;
    logic [JC_W-1:0] addr_mem_q, addr_mem_d;
    logic [JC_W-1:0] addr_grp_q, addr_grp_d;
    logic advance;
    logic hold_done;
    logic [IDX_W-1:0] addr_idx;

    assign advance = advance_latch_q && !latch_prev_q && (mode_q == RCS_RUN); // [R21] [R15]
    assign addr_idx = {jc_index(addr_grp_q), jc_index(addr_mem_q)};
    // Hold counted in ref_clk cycles in place of a charge time
    assign hold_done = por_cnt_q >= POR_CNT_W'(POR_HOLD_CYCLES - 1);

    always_comb begin
        // Off dominates a simultaneous on
        advance_latch_d = advance_latch_q;
        if (off_s) begin
            advance_latch_d = 1'b0; // [R9]
        end else if (on_s) begin
            advance_latch_d = 1'b1; // [R9]
        end
        latch_prev_d = advance_latch_q;
        mode_d = mode_q;
        por_cnt_d = por_cnt_q;
        case (mode_q)
            RCS_HOLD: begin
                if (hold_done) begin
                    mode_d = RCS_RUN; // [R14]
                end else begin
                    por_cnt_d = por_cnt_q + 1'b1;
                end
            end
            RCS_RUN: mode_d = RCS_RUN;
            default: mode_d = RCS_HOLD;
        endcase
        addr_mem_d = addr_mem_q;
        addr_grp_d = addr_grp_q;
        if (advance) begin
            // Both counters clocked together; group steps on member wrap
            addr_mem_d = {addr_mem_q[0], !addr_mem_q[1]}; // [R7] [R21]
            if (addr_mem_q == JC_S3) begin
                addr_grp_d = {addr_grp_q[0], !addr_grp_q[1]}; // [R6] [R7]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            advance_latch_q <= 1'b0;
            latch_prev_q <= 1'b0;
            mode_q <= RCS_HOLD;
            por_cnt_q <= '0;
            addr_mem_q <= MEM_RST; // [R14] [R15]
            addr_grp_q <= GRP_RST; // [R14] [R15]
        end else begin
            advance_latch_q <= advance_latch_d;
            latch_prev_q <= latch_prev_d;
            mode_q <= mode_d;
            por_cnt_q <= por_cnt_d;
            addr_mem_q <= addr_mem_d;
            addr_grp_q <= addr_grp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch tree decode with break-before-make
    // Both commutators take the same enables; analog wiring fixes
    // CH_VIDEO, CH_TIME_CODE, CH_GROUND_REF and CH_FULL_SCALE
    logic [VEC_W-1:0] sel, drv_q, drv_d;
    logic sel_video, sel_cal;

    assign sel_video = !advance_latch_q; // [R2] [R3] [R8]
    assign sel_cal = sel_video && (addr_idx == '0); // [R12]
    // [R1] [R4] [R11] [R16] [R19]
    assign sel = {sel_cal, sel_video, advance_latch_q, jc_decode(addr_grp_q), jc_decode(addr_mem_q)};

    // Any change passes through one all-off cycle
    always_comb begin
        drv_d = sel;
        if ((drv_q != '0) && (drv_q != sel)) begin
            drv_d = '0; // [R13]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign frame_cal_sel_q = drv_q[VEC_W-1];
    assign video_path_en_q = drv_q[VEC_W-2];
    assign tlm_path_en_q = drv_q[VEC_W-3];
    assign group_en_q = drv_q[2*EN_W-1:EN_W];
    assign member_en_q = drv_q[EN_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Marker divider and sync level conditioner
    logic mark_prev_q, mark_prev_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic sync_neg_d;
    logic mark_edge;

    assign mark_edge = mark_s && !mark_prev_q;

    always_comb begin
        mark_prev_d = mark_s;
        div_d = div_q;
        if (mark_edge) begin
            div_d = div_q + 1'b1; // [R17]
        end
        sync_neg_d = !spg_s; // [R20]
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mark_prev_q <= 1'b0;
            div_q <= '0;
            sync_neg_drive_q <= 1'b0;
        end else begin
            mark_prev_q <= mark_prev_d;
            div_q <= div_d;
            sync_neg_drive_q <= sync_neg_d;
        end
    end

    assign marker_ir_q = div_q[DIV_TAP_300]; // [R18]
    assign marker_vis_q = div_q[DIV_TAP_150]; // [R18]

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_path_exclusive: assert property (!(tlm_path_en_q && video_path_en_q)) // [R5]
        else $error("video and telemetry paths both enabled");
    a_tlm_route: assert property (tlm_path_en_q |-> $onehot(group_en_q) && $onehot(member_en_q)) // [R5]
        else $error("telemetry path without one group and one member");
    a_break_make: assert property ((drv_q != '0) && $changed(drv_q) |-> $past(drv_q) == '0) // [R13]
        else $error("switch change without an all-off gap");
    a_addr_step: assert property (advance |=> addr_idx == $past(addr_idx) + 1'b1) // [R21]
        else $error("address did not step by one");
    a_addr_stable: assert property (!advance |=> $stable(addr_idx)) // [R21]
        else $error("address moved without an advance");
    a_por_state: assert property (mode_q == RCS_HOLD |-> addr_idx == IDX_LAST && !advance) // [R14]
        else $error("address left state 32 during power-up hold");
    a_latch_set: assert property (on_s && !off_s |=> advance_latch_q ##1 sel_video == 1'b0) // [R9]
        else $error("latch not set by telemetry window");
    a_latch_clear: assert property (off_s |=> !advance_latch_q) // [R9]
        else $error("latch not cleared by video window");
    a_group_span: assert property (advance && addr_mem_q != JC_S3 |=> $stable(addr_grp_q)) // [R6]
        else $error("group moved inside its eight states");
    a_marker_div: assert property (mark_edge && div_q[2:0] == 3'h7 |=> marker_vis_q != $past(marker_vis_q)) // [R17]
        else $error("150 Hz marker missed its toggle");
    a_sync_level: assert property (spg_s |=> !sync_neg_drive_q ##1 1'b1) // [R20]
        else $error("sync output not grounded for high input");
    a_cal_state: assert property (frame_cal_sel_q |-> video_path_en_q && !tlm_path_en_q // [R12]
        && group_en_q == 4'h1 && member_en_q == 4'h1)
        else $error("frame calibration select outside state 2");

    // Advance latch, address register and power-up hold
    a_latch_hold: assert property (!on_s && !off_s |=> $stable(advance_latch_q)) // [R9]
        else $error("latch moved with both timing pins low");
    a_advance_once: assert property (advance |=> !advance) // [R21]
        else $error("two advances from one latch edge");
    a_run_sticky: assert property (mode_q == RCS_RUN |=> mode_q == RCS_RUN) // [R15]
        else $error("run mode left without reset");
    a_hold_release: assert property (mode_q == RCS_HOLD && hold_done |=> mode_q == RCS_RUN) // [R14]
        else $error("power-up hold did not end");
    a_member_step: assert property (advance |=> addr_mem_q != $past(addr_mem_q)) // [R6]
        else $error("member counter did not step");
    a_group_step: assert property (advance && addr_mem_q == JC_S3 |=> addr_grp_q != $past(addr_grp_q)) // [R6]
        else $error("group counter did not step on member wrap");

    // Switch drive
    a_switch_gap: assert property ($rose(tlm_path_en_q) || $rose(video_path_en_q) // [R13]
        |-> !$past(tlm_path_en_q) && !$past(video_path_en_q))
        else $error("path enabled without an all-off gap");
    a_tlm_select: assert property ($rose(advance_latch_q) |-> ##2 tlm_path_en_q && !video_path_en_q) // [R9]
        else $error("telemetry path not selected after latch set");
    a_video_select: assert property ($fell(advance_latch_q) |-> ##2 video_path_en_q && !tlm_path_en_q) // [R3]
        else $error("video path not selected after latch clear");
    a_path_one: assert property (drv_q != '0 |-> tlm_path_en_q != video_path_en_q) // [R4]
        else $error("selection without exactly one path");

    // Markers and sync level
    a_div_stable: assert property (!mark_edge |=> $stable(div_q)) // [R17]
        else $error("marker divider moved without an edge");
    a_marker_ir: assert property (mark_edge && div_q[1:0] == 2'h3 |=> marker_ir_q != $past(marker_ir_q)) // [R18]
        else $error("300 Hz marker missed its toggle");
    a_sync_neg: assert property (!spg_s |=> sync_neg_drive_q) // [R20]
        else $error("sync output not driven for low input");

    c_advance: cover property (advance ##[1:8] tlm_path_en_q);
    c_frame_wrap: cover property (advance && addr_idx == IDX_LAST);
    c_cal_select: cover property (frame_cal_sel_q);
    c_marker_150: cover property (mark_edge && div_q == 4'hF);
    c_hold_refused: cover property (mode_q == RCS_HOLD && advance_latch_q && !latch_prev_q);
endmodule

// ===== tb/rcs_radiometer_model.sv
// Radiometer timing pins and marker reference model
`timescale 1ns/1ps
module rcs_radiometer_model (
    // Timing pins
    output logic telemetry_window_begin,
    output logic video_window_begin,
    // Marker reference
    output logic marker_ref_2k4
);
    logic link_clk = 1'b0;
    logic mark_run = 1'b0;
    initial begin
        telemetry_window_begin = 1'b0;
        video_window_begin = 1'b0;
        marker_ref_2k4 = 1'b0;
    end
    always #32 link_clk = ~link_clk;
    // Follows every link edge only while asked for
    always @(link_clk) begin
        if (mark_run) begin
            marker_ref_2k4 <= ~marker_ref_2k4;
        end
    end
    // One mirror edge; the two pins are never high together
    task automatic pulse(input logic tlm, input int hold);
        @(posedge link_clk);
        telemetry_window_begin <= tlm;
        video_window_begin <= ~tlm;
        repeat (hold) @(posedge link_clk);
        telemetry_window_begin <= 1'b0;
        video_window_begin <= 1'b0;
    endtask
endmodule

// ===== tb/radiometer_commutator_sequencer_tb.sv
// Self-checking bench for the commutator sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t: got %0h exp %0h", $time, a, b); end end
module radiometer_commutator_sequencer_tb;
    import rcs_pkg::*;
    localparam int HOLD = 64;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sync_pulse_gate_out = 1'b1;
    logic telemetry_window_begin, video_window_begin, marker_ref_2k4;
    logic [EN_W-1:0] group_en_q, member_en_q;
    logic tlm_path_en_q, video_path_en_q, frame_cal_sel_q;
    logic marker_ir_q, marker_vis_q, sync_neg_drive_q;
    logic [IDX_W-1:0] idx;
    int fails = 0;
    int cmp_count = 0;
    always #2.5 ref_clk = ~ref_clk;
    rcs_radiometer_model part_u (
        .telemetry_window_begin(telemetry_window_begin),
        .video_window_begin(video_window_begin),
        .marker_ref_2k4(marker_ref_2k4)
    );
    rcs_sequencer #(.POR_HOLD_CYCLES(HOLD)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .telemetry_window_begin(telemetry_window_begin),
        .video_window_begin(video_window_begin),
        .marker_ref_2k4(marker_ref_2k4), .sync_pulse_gate_out(sync_pulse_gate_out),
        .group_en_q(group_en_q), .member_en_q(member_en_q),
        .tlm_path_en_q(tlm_path_en_q), .video_path_en_q(video_path_en_q),
        .frame_cal_sel_q(frame_cal_sel_q), .marker_ir_q(marker_ir_q),
        .marker_vis_q(marker_vis_q), .sync_neg_drive_q(sync_neg_drive_q)
    );
    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_sel(input logic tlm);
        `CHK(group_en_q, 4'h1 << idx[3:2])
        `CHK(member_en_q, 4'h1 << idx[1:0])
        `CHK(tlm_path_en_q, tlm)
        `CHK(video_path_en_q, ~tlm)
        `CHK(frame_cal_sel_q, ~tlm && idx == 4'h0)
    endtask
    // Mirror edge, then wait for the gap and the new selection
    task automatic step(input logic tlm, input logic mv, input logic gap, input int hold);
        logic zero;
        logic done;
        zero = 1'b0;
        done = 1'b0;
        idx = idx + {3'h0, mv};
        fork
            part_u.pulse(tlm, hold);
            for (int n = 0; n < 80 && !done; n++) begin
                @(negedge ref_clk);
                `CHK(tlm_path_en_q & video_path_en_q, 1'b0)
                if ({group_en_q, member_en_q, tlm_path_en_q, video_path_en_q} === 10'h000) begin
                    zero = 1'b1;
                end
                done = (zero === gap) && (tlm_path_en_q === tlm);
            end
        join
        if (!done) begin
            fails++;
            conclude();
        end
        `CHK(zero, gap)
        check_sel(tlm);
    endtask
    task automatic scen_power_up();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_sel(1'b0);
        step(1'b1, 1'b0, 1'b1, 2);
        repeat (HOLD) @(posedge ref_clk);
        step(1'b0, 1'b0, 1'b1, 2);
    endtask
    task automatic scen_frame();
        for (int i = 0; i < 16; i++) begin
            step(1'b1, 1'b1, 1'b1, 2);
            step(1'b0, 1'b0, 1'b1, (i == 5) ? 6 : 2);
        end
        step(1'b1, 1'b1, 1'b1, 2);
        step(1'b1, 1'b0, 1'b0, 2);
    endtask
    task automatic scen_markers();
        int r = 0;
        int ir = 0;
        int vs = 0;
        int tail = 0;
        logic rp = 1'b0;
        logic ip = 1'b0;
        logic vp = 1'b0;
        part_u.mark_run = 1'b1;
        for (int n = 0; n < 700 && tail < 10; n++) begin
            @(negedge ref_clk);
            r += int'(marker_ref_2k4 && !rp);
            ir += int'(marker_ir_q && !ip);
            vs += int'(marker_vis_q && !vp);
            rp = marker_ref_2k4;
            ip = marker_ir_q;
            vp = marker_vis_q;
            if (r == 16) begin
                part_u.mark_run = 1'b0;
                tail++;
            end
        end
        `CHK(r, 16)
        `CHK(ir, 2)
        `CHK(vs, 1)
    endtask
    task automatic scen_sync_level();
        for (int v = 0; v < 2; v++) begin
            @(posedge ref_clk);
            sync_pulse_gate_out <= v[0];
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK(sync_neg_drive_q, ~v[0])
        end
    endtask
    task automatic scen_mid_reset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(negedge ref_clk);
        `CHK({group_en_q, member_en_q, tlm_path_en_q, video_path_en_q}, 10'h000)
        @(posedge ref_clk);
        reset_n <= 1'b1;
        idx = IDX_LAST;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_sel(1'b0);
        repeat (HOLD) @(posedge ref_clk);
        step(1'b1, 1'b1, 1'b1, 2);
    endtask
    initial begin
        idx = IDX_LAST;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({group_en_q, member_en_q, tlm_path_en_q, video_path_en_q}, 10'h000)
        @(posedge ref_clk);
        reset_n <= 1'b1;
        scen_power_up();
        scen_frame();
        scen_markers();
        scen_sync_level();
        scen_mid_reset();
        conclude();
    end
endmodule
